//--- hw/kmp_pkg.sv
package kmp_pkg;

   // ----------------------------------------------------------------
   // Register map, byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_SCAN_PORT = 8'h00;
   localparam logic [7:0] ADDR_INPUT_PORT = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam logic [7:0] ADDR_STATUS_CMD = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;

   // ----------------------------------------------------------------
   // Reset values and fixed fields
   // ----------------------------------------------------------------
   localparam logic [7:0] SCAN_LATCH_RST = 8'hFF;
   localparam logic [7:0] CTRL_RST = 8'h26;
   localparam logic [7:0] CTRL_WR_MASK = 8'h37;
   localparam logic [1:0] INPUT_PORT_LOW = 2'h3;
   localparam logic IND_LEVEL_RST = 1'b1;

   // ----------------------------------------------------------------
   // Status command fields
   // ----------------------------------------------------------------
   localparam int CMD_TEST_BIT = 4;
   localparam int CMD_HALT_BIT = 5;
   localparam int OPD_SENSE_BIT = 3;
   localparam logic [2:0] OPD_KEY_A = 3'h0;
   localparam logic [2:0] OPD_KEY_B = 3'h3;
   localparam logic [2:0] OPD_KEY_C = 3'h6;
   localparam logic [2:0] OPD_TIMER = 3'h5;
   localparam logic [3:0] OPD_RST = 4'h0;

   // ----------------------------------------------------------------
   // Bus responses
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Second control register layout
   typedef struct packed {
      logic [1:0] fixed_hi;
      logic key_ret_pd;
      logic sense_pd;
      logic fixed_b3;
      logic indicator_out;
      logic scan_out;
      logic sense_in;
   } kmp_ctrl_t;

   typedef enum logic [1:0] {
      WS_IDLE = 2'b01,
      WS_RESP = 2'b10
   } kmp_wstate_t;

endpackage : kmp_pkg

//--- hw/kmp_port_regs.sv
`timescale 1ns/1ps
// What this block does
// - Scan port reads pins or latch by mode
// - Scan port write always updates latch
// - Control bit 1 sets scan direction
// - Reset: scan port output, latch all ones
// - Scan pull-down only in input mode
// - Key return levels in upper nibble
// - Control bit 5 enables key-return pull-downs
// - Sense bit reads pin, or 1 off
// - Control bit 0 selects sense input/off
// - Control bit 4 enables both sense pull-downs
// - Reset puts sense input off mode
// - Bit 3 reads indicator pin level always
// - Key codes set flag on any key
// - Timer code sets flag on zero count
// - Operand bit 3 adds sense pin levels
// - Release or met halt sets flag
// - Unmet halt with flag set clears it
// - Control bit 2 selects indicator output
// - Pull-downs off in output or off mode
module kmp_port_regs (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // AXI4-Lite write address
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   // AXI4-Lite write data
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   // AXI4-Lite write response
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // AXI4-Lite read address
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   // AXI4-Lite read data
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // Key scan pins
   input wire logic [7:0] KEY_SCAN_IO_I,
   output logic [7:0] KEY_SCAN_IO_O,
   output logic KEY_SCAN_IO_OE_B,
   output logic KEY_SCAN_IO_PD,
   // Key return pins
   input wire logic [3:0] KEY_RETURN_INPUT,
   output logic KEY_RETURN_INPUT_PD,
   // Sense input pin
   input wire logic SENSE_INPUT,
   output logic SENSE_INPUT_EN,
   output logic SENSE_INPUT_PD,
   // Sense or indicator pin
   input wire logic SENSE_OR_INDICATOR_PIN_I,
   output logic SENSE_OR_INDICATOR_PIN_O,
   output logic SENSE_OR_INDICATOR_PIN_OE_B,
   output logic SENSE_OR_INDICATOR_PIN_PD,
   input wire logic INDICATOR_LEVEL,
   // Timer and standby
   input wire logic TIMER_ZERO,
   input wire logic STANDBY_RELEASE,
   output logic STATUS_FLAG,
   output logic STANDBY
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   kmp_pkg::kmp_wstate_t wstate_reg;
   kmp_pkg::kmp_wstate_t wstate_next;
   kmp_pkg::kmp_ctrl_t ctrl_reg;
   logic [7:0] scan_latch_reg;
   logic ind_level_reg;
   logic flag_reg;
   logic flag_next;
   logic standby_reg;
   logic standby_next;
   logic [3:0] halt_opd_reg;
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   // ----------------------------------------------------------------
   // Condition decode, shared by test and halt
   // ----------------------------------------------------------------
   function automatic logic cond_met(input logic [3:0] opd,
      input logic [3:0] keys, input logic tzero, input logic sense);
      logic key_code;
      logic base;
      key_code = (opd[2:0] == kmp_pkg::OPD_KEY_A) ||
         (opd[2:0] == kmp_pkg::OPD_KEY_B) ||
         (opd[2:0] == kmp_pkg::OPD_KEY_C);
      base = (key_code && (|keys)) ||
         ((opd[2:0] == kmp_pkg::OPD_TIMER) && tzero);
      cond_met = base || (opd[kmp_pkg::OPD_SENSE_BIT] && sense);
   endfunction : cond_met

   // ----------------------------------------------------------------
   // Address decode, shared by write and read
   // ----------------------------------------------------------------
   function automatic logic addr_mapped(input logic [7:0] addr);
      addr_mapped = (addr == kmp_pkg::ADDR_SCAN_PORT) ||
         (addr == kmp_pkg::ADDR_INPUT_PORT) ||
         (addr == kmp_pkg::ADDR_CTRL) ||
         (addr == kmp_pkg::ADDR_STATUS_CMD) ||
         (addr == kmp_pkg::ADDR_STATUS);
   endfunction : addr_mapped

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
   wire w_take = S_AXI_WVALID && S_AXI_WREADY;
   wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
   wire do_write = (wstate_reg == kmp_pkg::WS_IDLE) && aw_hold_reg &&
      w_hold_reg;
   wire lane0 = wstrb_reg[0];
   wire wr_scan = do_write && lane0 &&
      (awaddr_reg == kmp_pkg::ADDR_SCAN_PORT);
   wire wr_ctrl = do_write && lane0 && (awaddr_reg == kmp_pkg::ADDR_CTRL);
   wire wr_cmd = do_write && lane0 &&
      (awaddr_reg == kmp_pkg::ADDR_STATUS_CMD);
   wire wr_mapped = addr_mapped(awaddr_reg);
   wire do_test = wr_cmd && wdata_reg[kmp_pkg::CMD_TEST_BIT];
   wire do_halt = wr_cmd && wdata_reg[kmp_pkg::CMD_HALT_BIT] && !do_test;

   // ----------------------------------------------------------------
   // Port read values
   // ----------------------------------------------------------------
   wire [7:0] scan_rd = ctrl_reg.scan_out ? scan_latch_reg :
      KEY_SCAN_IO_I;
   wire sense_rd = ctrl_reg.sense_in ? SENSE_INPUT : 1'b1;
   wire [7:0] input_rd = {KEY_RETURN_INPUT,
      SENSE_OR_INDICATOR_PIN_I, sense_rd,
      kmp_pkg::INPUT_PORT_LOW};
   // Off-mode sense pin has no input buffer, so it cannot count as high
   wire sense_high = (ctrl_reg.sense_in && SENSE_INPUT) ||
      SENSE_OR_INDICATOR_PIN_I;
   wire test_cond = cond_met(wdata_reg[3:0], KEY_RETURN_INPUT, TIMER_ZERO,
      sense_high);
   wire wait_cond = cond_met(halt_opd_reg, KEY_RETURN_INPUT, TIMER_ZERO,
      sense_high);
   wire release_evt = STANDBY_RELEASE || (standby_reg && wait_cond);
   wire [7:0] ar_addr = S_AXI_ARADDR;
   wire ar_mapped = addr_mapped(ar_addr);
   wire [7:0] rd_byte =
      (ar_addr == kmp_pkg::ADDR_SCAN_PORT) ? scan_rd :
      (ar_addr == kmp_pkg::ADDR_INPUT_PORT) ? input_rd :
      (ar_addr == kmp_pkg::ADDR_CTRL) ? ctrl_reg :
      (ar_addr == kmp_pkg::ADDR_STATUS) ?
      {6'h00, standby_reg, flag_reg} : 8'h00;

   // ----------------------------------------------------------------
   // Handshake outputs
   // ----------------------------------------------------------------
   assign S_AXI_AWREADY = (wstate_reg == kmp_pkg::WS_IDLE) && !aw_hold_reg;
   assign S_AXI_WREADY = (wstate_reg == kmp_pkg::WS_IDLE) && !w_hold_reg;
   assign S_AXI_BVALID = (wstate_reg == kmp_pkg::WS_RESP);
   assign S_AXI_BRESP = bresp_reg;
   assign S_AXI_ARREADY = !rvalid_reg;
   assign S_AXI_RVALID = rvalid_reg;
   assign S_AXI_RDATA = rdata_reg;
   assign S_AXI_RRESP = rresp_reg;

   // ----------------------------------------------------------------
   // Write state and flag logic
   // ----------------------------------------------------------------
   always_comb
   begin
      case (wstate_reg)
         kmp_pkg::WS_IDLE: wstate_next = do_write ? kmp_pkg::WS_RESP :
            kmp_pkg::WS_IDLE;
         kmp_pkg::WS_RESP: wstate_next = S_AXI_BREADY ? kmp_pkg::WS_IDLE :
            kmp_pkg::WS_RESP;
         default: wstate_next = kmp_pkg::WS_IDLE;
      endcase
   end

   // Release is applied last so it wins over a same-cycle clear
   always_comb
   begin
      flag_next = flag_reg;
      standby_next = standby_reg;
      if (do_test)
         flag_next = test_cond;
      else if (do_halt)
      begin
         if (test_cond)
            flag_next = 1'b1;
         else if (flag_reg)
            flag_next = 1'b0;
         else
            standby_next = 1'b1;
      end
      if (release_evt)
      begin
         flag_next = 1'b1;
         standby_next = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
         wstate_reg <= kmp_pkg::WS_IDLE;
      else
         wstate_reg <= wstate_next;
   end

   // Address and data may arrive in either order, so each is held
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
      end
      else
      begin
         aw_hold_reg <= (aw_hold_reg || aw_take) && !do_write;
         w_hold_reg <= (w_hold_reg || w_take) && !do_write;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
         awaddr_reg <= 8'h00;
      else if (aw_take)
         awaddr_reg <= S_AXI_AWADDR;
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
      end
      else if (w_take)
      begin
         wdata_reg <= S_AXI_WDATA;
         wstrb_reg <= S_AXI_WSTRB;
      end
   end

   // Response code is fixed at the write edge and held until taken
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
         bresp_reg <= kmp_pkg::RESP_OKAY;
      else if (do_write)
         bresp_reg <= wr_mapped ? kmp_pkg::RESP_OKAY :
            kmp_pkg::RESP_SLVERR;
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   // Next address waits until the data is taken
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
         rvalid_reg <= 1'b0;
      else if (ar_take)
         rvalid_reg <= 1'b1;
      else if (S_AXI_RREADY)
         rvalid_reg <= 1'b0;
   end

   // Pins are sampled once, at the address edge, so data stays put
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         rdata_reg <= 32'h00000000;
         rresp_reg <= kmp_pkg::RESP_OKAY;
      end
      else if (ar_take)
      begin
         rdata_reg <= {24'h000000, rd_byte};
         rresp_reg <= ar_mapped ? kmp_pkg::RESP_OKAY : kmp_pkg::RESP_SLVERR;
      end
   end

   // ----------------------------------------------------------------
   // Port registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
         scan_latch_reg <= kmp_pkg::SCAN_LATCH_RST;
      else if (wr_scan)
         scan_latch_reg <= wdata_reg[7:0];
   end

   // Fixed bits are masked here so they always read back as zero
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
         ctrl_reg <= kmp_pkg::CTRL_RST;
      else if (wr_ctrl)
         ctrl_reg <= wdata_reg[7:0] & kmp_pkg::CTRL_WR_MASK;
   end

   // One register stage keeps the indicator pin free of input glitches
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
         ind_level_reg <= kmp_pkg::IND_LEVEL_RST;
      else
         ind_level_reg <= INDICATOR_LEVEL;
   end

   // ----------------------------------------------------------------
   // Flag and standby registers
   // ----------------------------------------------------------------
   // Operand kept so the wake test still has it while standing by
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
         halt_opd_reg <= kmp_pkg::OPD_RST;
      else if (do_halt)
         halt_opd_reg <= wdata_reg[3:0];
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         flag_reg <= 1'b0;
         standby_reg <= 1'b0;
      end
      else
      begin
         flag_reg <= flag_next;
         standby_reg <= standby_next;
      end
   end

   // ----------------------------------------------------------------
   // Pin drive, all from registers
   // ----------------------------------------------------------------
   // Direction is one control bit for all eight lines, never per bit
   assign KEY_SCAN_IO_O = scan_latch_reg;
   assign KEY_SCAN_IO_OE_B = !ctrl_reg.scan_out;
   assign KEY_SCAN_IO_PD = !ctrl_reg.scan_out;
   assign KEY_RETURN_INPUT_PD = ctrl_reg.key_ret_pd;
   assign SENSE_INPUT_EN = ctrl_reg.sense_in;
   assign SENSE_INPUT_PD = ctrl_reg.sense_pd && ctrl_reg.sense_in;
   assign SENSE_OR_INDICATOR_PIN_O = ind_level_reg;
   assign SENSE_OR_INDICATOR_PIN_OE_B = !ctrl_reg.indicator_out;
   assign SENSE_OR_INDICATOR_PIN_PD = ctrl_reg.sense_pd &&
      !ctrl_reg.indicator_out;
   assign STATUS_FLAG = flag_reg;
   assign STANDBY = standby_reg;

endmodule : kmp_port_regs

//--- tb/kmp_key_matrix.sv
`timescale 1ns/1ps
// ----------------
// Key matrix model
// ----------------
module kmp_key_matrix (
   // Device side
   input wire logic [7:0] scan_o,
   input wire logic scan_oe_b,
   input wire logic ind_o,
   input wire logic ind_oe_b,
   // Switch side
   input wire logic [7:0] scan_ext,
   input wire logic s1_ext,
   output logic [7:0] scan_i,
   output logic s1_i
);
   // A driven pin wins over the switches
   assign scan_i = scan_oe_b ? scan_ext : scan_o;
   assign s1_i = ind_oe_b ? s1_ext : ind_o;
endmodule : kmp_key_matrix

//--- tb/kmp_port_checker.sv
`timescale 1ns/1ps
module kmp_port_checker (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // Bus
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // Pins
   input wire logic [7:0] KEY_SCAN_IO_O,
   input wire logic KEY_SCAN_IO_OE_B,
   input wire logic KEY_SCAN_IO_PD,
   input wire logic SENSE_INPUT_EN,
   input wire logic SENSE_INPUT_PD,
   input wire logic SENSE_OR_INDICATOR_PIN_OE_B,
   input wire logic SENSE_OR_INDICATOR_PIN_PD,
   // Status
   input wire logic STANDBY_RELEASE,
   input wire logic STATUS_FLAG,
   input wire logic STANDBY
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   sequence s_woken;
      !STANDBY && STATUS_FLAG;
   endsequence
   a_scan_pd_in: assert property (KEY_SCAN_IO_PD |-> KEY_SCAN_IO_OE_B)
      else $error("scan pull-down while driving");
   a_ind_pd_in: assert property (
      SENSE_OR_INDICATOR_PIN_PD |-> SENSE_OR_INDICATOR_PIN_OE_B)
      else $error("indicator pull-down while driving");
   a_sense_pd_on: assert property (SENSE_INPUT_PD |-> SENSE_INPUT_EN)
      else $error("sense pull-down in off mode");
   a_reset_state: assert property (disable iff (1'b0)
      !RST_B |=> KEY_SCAN_IO_O == 8'hFF && !KEY_SCAN_IO_OE_B &&
      !SENSE_INPUT_EN)
      else $error("reset pin state wrong");
   a_release_flag: assert property (STANDBY_RELEASE |=> STATUS_FLAG)
      else $error("release did not set flag");
   a_standby_wake: assert property (
      STANDBY && STANDBY_RELEASE |=> s_woken)
      else $error("standby not left");
   a_no_stby_flag: assert property (
      $rose(STANDBY) |-> !$past(STATUS_FLAG))
      else $error("standby entered with flag set");
   a_rdata_hold: assert property (
      S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped");
   a_bresp_hold: assert property (
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
      else $error("write response dropped");
   a_ar_busy: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read taken while busy");
endmodule : kmp_port_checker
bind kmp_port_regs kmp_port_checker u_chk (.CLK(CLK), .RST_B(RST_B),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
   .KEY_SCAN_IO_O(KEY_SCAN_IO_O), .KEY_SCAN_IO_OE_B(KEY_SCAN_IO_OE_B),
   .KEY_SCAN_IO_PD(KEY_SCAN_IO_PD), .SENSE_INPUT_EN(SENSE_INPUT_EN),
   .SENSE_INPUT_PD(SENSE_INPUT_PD),
   .SENSE_OR_INDICATOR_PIN_OE_B(SENSE_OR_INDICATOR_PIN_OE_B),
   .SENSE_OR_INDICATOR_PIN_PD(SENSE_OR_INDICATOR_PIN_PD),
   .STANDBY_RELEASE(STANDBY_RELEASE), .STATUS_FLAG(STATUS_FLAG),
   .STANDBY(STANDBY));

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
   logic CLK = 1'b0, RST_B = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   logic [7:0] scan_i, scan_o, scan_ext = 8'h3C;
   logic scan_oe_b, scan_pd, kr_pd, s0_en, s0_pd, s1_i, s1_o, s1_oe_b, s1_pd;
   logic [3:0] kr = 4'h0;
   logic s0 = 1'b0, s1_ext = 1'b0, tz = 1'b0, ind = 1'b1, rel = 1'b0;
   logic flag, stby;
   int error_cnt = 0, checks = 0;
   always #5 CLK = ~CLK;
   kmp_port_regs u_kmp_port_regs (.CLK(CLK), .RST_B(RST_B),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .KEY_SCAN_IO_I(scan_i),
      .KEY_SCAN_IO_O(scan_o), .KEY_SCAN_IO_OE_B(scan_oe_b),
      .KEY_SCAN_IO_PD(scan_pd), .KEY_RETURN_INPUT(kr),
      .KEY_RETURN_INPUT_PD(kr_pd), .SENSE_INPUT(s0), .SENSE_INPUT_EN(s0_en),
      .SENSE_INPUT_PD(s0_pd), .SENSE_OR_INDICATOR_PIN_I(s1_i),
      .SENSE_OR_INDICATOR_PIN_O(s1_o), .SENSE_OR_INDICATOR_PIN_OE_B(s1_oe_b),
      .SENSE_OR_INDICATOR_PIN_PD(s1_pd), .INDICATOR_LEVEL(ind),
      .TIMER_ZERO(tz), .STANDBY_RELEASE(rel), .STATUS_FLAG(flag),
      .STANDBY(stby));
   kmp_key_matrix u_kmp_key_matrix (.scan_o(scan_o), .scan_oe_b(scan_oe_b),
      .ind_o(s1_o), .ind_oe_b(s1_oe_b), .scan_ext(scan_ext),
      .s1_ext(s1_ext), .scan_i(scan_i), .s1_i(s1_i));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   // Ready is looked at mid-cycle, acted on at the next rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
      input logic [1:0] e);
      logic ta, tw, tb_;
      @(posedge CLK);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      repeat (40)
      begin
         @(negedge CLK);
         ta = awready;
         tw = wready;
         tb_ = bvalid;
         rs = bresp;
         @(posedge CLK);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb_ && bready) break;
         bready <= tb_;
      end
      bready <= 1'b0;
      if (!(tb_ && bready))
      begin
         error_cnt++;
         conclude();
      end
      chk({30'h0, rs}, {30'h0, e});
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [7:0] d,
      input logic [1:0] e);
      logic ta, ok;
      @(posedge CLK);
      araddr <= a;
      arvalid <= 1'b1;
      repeat (40)
      begin
         @(negedge CLK);
         ta = arready;
         ok = rvalid;
         rd = rdata;
         rs = rresp;
         @(posedge CLK);
         if (ta) arvalid <= 1'b0;
         if (ok && rready) break;
         rready <= ok;
      end
      rready <= 1'b0;
      if (!(ok && rready))
      begin
         error_cnt++;
         conclude();
      end
      chk(rd, {24'h0, d});
      chk({30'h0, rs}, {30'h0, e});
   endtask : rdc
   // Bits: keys, sense, switch on indicator pin, timer zero, level, release
   task automatic drv(input logic [8:0] v);
      @(posedge CLK);
      {kr, s0, s1_ext, tz, ind, rel} <= v;
   endtask : drv
   initial
   begin
      repeat (6) @(posedge CLK);
      RST_B <= 1'b1;
      @(negedge CLK);
      chk({20'h0, scan_o, scan_oe_b, kr_pd, s0_en, s1_oe_b},
         32'h00000FF4);
      rdc(8'h08, 8'h26, 2'h0);
      rdc(8'h00, 8'hFF, 2'h0);
      $display("reset test done");
      wr(8'h00, 8'h5A, 2'h0);
      rdc(8'h00, 8'h5A, 2'h0);
      wr(8'h08, 8'hFF, 2'h0);
      rdc(8'h08, 8'h37, 2'h0);
      wr(8'h08, 8'h31, 2'h0);
      wr(8'h00, 8'hA5, 2'h0);
      chk({18'h0, scan_o, scan_oe_b, scan_pd, s0_en, s0_pd, s1_oe_b, s1_pd},
         32'h0000297F);
      rdc(8'h00, 8'h3C, 2'h0);
      drv({4'h9, 5'b00010});
      rdc(8'h04, 8'h93, 2'h0);
      drv({4'h9, 5'b11010});
      rdc(8'h04, 8'h9F, 2'h0);
      wr(8'h08, 8'h34, 2'h0);
      drv({4'h9, 5'b01000});
      rdc(8'h04, 8'h97, 2'h0);
      chk({26'h0, scan_pd, s0_en, s0_pd, s1_oe_b, s1_pd, kr_pd},
         32'h00000021);
      $display("port test done");
      wr(8'h08, 8'h31, 2'h0);
      drv({4'h1, 5'b00010});
      for (int c = 0; c < 8; c++)
      begin
         wr(8'h0C, 8'h10 | c[7:0], 2'h0);
         rdc(8'h10, {7'h0, c == 0 || c == 3 || c == 6}, 2'h0);
      end
      drv({4'h0, 5'b00110});
      wr(8'h0C, 8'h15, 2'h0);
      rdc(8'h10, 8'h01, 2'h0);
      drv({4'h0, 5'b10010});
      wr(8'h0C, 8'h10, 2'h0);
      rdc(8'h10, 8'h00, 2'h0);
      wr(8'h0C, 8'h18, 2'h0);
      rdc(8'h10, 8'h01, 2'h0);
      $display("status test done");
      drv({4'h0, 5'b00010});
      wr(8'h0C, 8'h20, 2'h0);
      rdc(8'h10, 8'h00, 2'h0);
      wr(8'h0C, 8'h20, 2'h0);
      rdc(8'h10, 8'h02, 2'h0);
      chk({30'h0, stby, flag}, 32'h00000002);
      drv({4'h1, 5'b00010});
      rdc(8'h10, 8'h01, 2'h0);
      wr(8'h0C, 8'h20, 2'h0);
      rdc(8'h10, 8'h01, 2'h0);
      drv({4'h0, 5'b00010});
      wr(8'h0C, 8'h20, 2'h0);
      wr(8'h0C, 8'h20, 2'h0);
      drv({4'h0, 5'b00011});
      drv({4'h0, 5'b00010});
      rdc(8'h10, 8'h01, 2'h0);
      $display("halt test done");
      wr(8'h14, 8'h55, 2'h2);
      rdc(8'h14, 8'h00, 2'h2);
      wr(8'h04, 8'h00, 2'h0);
      $display("map test done");
      conclude();
   end
endmodule : tb
